// ### design/sfs_pkg.sv
`default_nettype none
package sfs_pkg;
  // clock and time figures
  localparam int CLK_NS          = 8;
  localparam int NS_PER_MS       = 1000000;
  localparam int LOWBUS_DEB_MS   = 50;
  localparam int CFG_HOLD_MS     = 10000;
  localparam int LAMP_TEST_MS    = 1000;
  localparam int EN_TOGGLE_MS    = 100;
  // least times round up, the lamp test (a longest time) is one cycle less, since lamp_q holds one cycle past the count's end, so it lasts exactly 1 s
  localparam int LOWBUS_CYC      = (LOWBUS_DEB_MS * NS_PER_MS + CLK_NS - 1) / CLK_NS;
  localparam int CFG_HOLD_CYC    = (CFG_HOLD_MS / 10) * (NS_PER_MS / CLK_NS) * 10;
  localparam int LAMP_CYC        = (LAMP_TEST_MS * (NS_PER_MS / CLK_NS)) - 1;
  localparam int EN_TOGGLE_CYC   = (EN_TOGGLE_MS * NS_PER_MS) / CLK_NS;
  // thresholds
  localparam logic [9:0]  HIGH_BUS_V      = 10'h1B8;
  localparam logic [9:0]  LOW_BUS_V       = 10'h060;
  localparam logic [15:0] PULSE_RPM_MAX   = 16'h32C8;
  localparam logic [7:0]  SEC_PER_MIN     = 8'h3C;
  localparam logic [15:0] FE_LIMIT_RST    = 16'h00C8;
  localparam logic [15:0] SPEED_CEIL_RST  = 16'h1770;
  localparam logic [15:0] MOTOR_MAX_RST   = 16'h1770;
  localparam logic [15:0] PULSE_RATIO_RST = 16'h0800;
  localparam logic [7:0]  PCT_FULL        = 8'h64;
  localparam logic [7:0]  PCT_FOLD        = 8'h50;
  // register byte addresses
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_SPEED_CEIL  = 8'h04;
  localparam logic [7:0] REG_MOTOR_MAX   = 8'h08;
  localparam logic [7:0] REG_FE_LIMIT    = 8'h0C;
  localparam logic [7:0] REG_PULSE_RATIO = 8'h10;
  localparam logic [7:0] REG_FAULTS      = 8'h14;
  localparam logic [7:0] REG_POSITION    = 8'h18;
  localparam logic [7:0] REG_DISPLAY     = 8'h1C;
  localparam logic [7:0] CTRL_RST        = 8'h03;
  // fault indices, highest rank first
  localparam int NFLT = 13;
  localparam int F_PUT = 0, F_MEM = 1, F_CFG = 2, F_PWR = 3, F_HBUS = 4, F_LBUS = 5;
  localparam int F_ENCS = 6, F_ENCH = 7, F_MOT = 8, F_SHUNT = 9, F_OSPD = 10;
  localparam int F_FERR = 11, F_TRAV = 12;
  localparam logic [NFLT-1:0] RESET_MASK  = 13'h0F3A;
  localparam logic [NFLT-1:0] BRIDGE_MASK = 13'h0FFF;
  // operating modes
  typedef enum logic [2:0] {
    MODE_PULSE    = 3'b000,
    MODE_VELOCITY = 3'b001,
    MODE_TORQUE   = 3'b010,
    MODE_SUM_PLS  = 3'b011,
    MODE_SUM_VEL  = 3'b100
  } sfs_mode_e;
  // display indications: fault codes are 1 + fault index
  typedef enum logic [4:0] {
    DSP_NONE     = 5'b00000,
    DSP_BRAKE    = 5'b10000,
    DSP_DISABLED = 5'b10001,
    DSP_POSITION = 5'b10010,
    DSP_VELOCITY = 5'b10011,
    DSP_TORQUE   = 5'b10100,
    DSP_SUMMING  = 5'b10101,
    DSP_RMSFOLD  = 5'b10110,
    DSP_STALL    = 5'b10111,
    DSP_ALL_ON   = 5'b11111
  } sfs_disp_e;
  typedef struct packed {
    logic enc_chk_en;
    logic fe_chk_en;
    logic brake_assigned;
    logic [2:0] mode;
  } sfs_ctrl_s;
  // asynchronous pins, passed through the synchroniser as one word
  typedef struct packed {
    logic reset_btn;
    logic reset_in;
    logic enable_in;
    logic stop_in;
    logic therm_open;
    logic lim_pos;
    logic lim_neg;
    logic ps_overtemp;
    logic ps_overcur;
    logic ps_logic_loss;
    logic shunt_over;
    logic rms_fold;
    logic stall_fold;
    logic brake_engaged;
    logic module_prev;
    logic [2:0] hall;
    logic [5:0] enc;
  } sfs_pins_s;
endpackage
`default_nettype wire

// ### design/sfs_supervisor.sv
`default_nettype none
module sfs_supervisor
  import sfs_pkg::*;
#(
  parameter int LOWBUS_CYCLES = LOWBUS_CYC,
  parameter int CFG_HOLD_CYCLES = CFG_HOLD_CYC,
  parameter int LAMP_CYCLES = LAMP_CYC,
  parameter int EN_TOGGLE_CYCLES = EN_TOGGLE_CYC
)(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // asynchronous condition pins
  input  wire sfs_pins_s   pins,
  // same-clock measurements
  input  wire logic [9:0]  bus_volts,
  input  wire logic [15:0] speed_rpm,
  input  wire logic [15:0] follow_err,
  input  wire logic [19:0] pulse_hz,
  input  wire logic        selftest_fail,
  input  wire logic        mem_check_done,
  input  wire logic        mem_check_ok,
  input  wire logic        motion_cmd,
  // outputs
  output logic             bridge_en,
  output logic             motion_en,
  output logic [4:0]       disp_code,
  output logic             disp_dp,
  output logic             torque_clamp_state,
  output logic [7:0]       torque_limit_pct,
  output logic [7:0]       current_limit_pct
);
  localparam int PW = $bits(sfs_pins_s);
  logic [PW-1:0]     sync1_q, sync2_q;
  sfs_pins_s         s;
  logic              strap_done_q, cfg_strap_q;
  logic [1:0]        ab_q;
  logic [2:0]        btn_hist_q;
  logic              en_prev_q;
  logic [31:0]       en_cnt_q, lowbus_cnt_q, hold_cnt_q, lamp_cnt_q, pos_q;
  logic              lamp_q;
  logic [NFLT-1:0]   flt_q, flt_d, cond, clr;
  sfs_ctrl_s         ctrl_q;
  logic [15:0]       speed_ceil_q, motor_max_q, fe_limit_q, pulse_ratio_q;
  logic              pulse_mode, enc_illegal, ready, reset_pulse, en_rise, hold_done;
  logic [1:0]        ab_now;
  logic [39:0]       pls_lhs, pls_rhs;
  logic [17:0]       spd_x2;
  logic [17:0]       max_x3;
  logic [3:0]        top_idx;
  logic              any_flt;
  sfs_disp_e         disp_d;

  // two-flop synchroniser for every pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end
  assign s = sfs_pins_s'(sync2_q);

  // module-attached strap caught just after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_done_q <= 1'b0;
      cfg_strap_q  <= 1'b0;
    end
    else if (!strap_done_q && lamp_cnt_q > 32'd2)
    begin
      strap_done_q <= 1'b1;
      cfg_strap_q  <= s.module_prev;
    end
    else if (!lamp_q)
      cfg_strap_q  <= 1'b0; // one-shot: fault latches once, only the hold clears it
  end

  // quadrature decode and position count, independent of faults
  assign ab_now = {s.enc[5], s.enc[3]};
  assign enc_illegal = ((ab_now ^ ab_q) == 2'b11) || (s.hall == 3'b000) || (s.hall == 3'b111);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ab_q  <= '0;
      pos_q <= '0;
    end
    else
    begin
      ab_q <= ab_now;
      if ((ab_now ^ ab_q) == 2'b01 || (ab_now ^ ab_q) == 2'b10)
      begin
        if (ab_q[1] ^ ab_now[0])
          pos_q <= pos_q + 32'd1;
        else
          pos_q <= pos_q - 32'd1;
      end
    end
  end

  // enable toggle rate watch and reset button history
  assign en_rise = s.enable_in && !en_prev_q;
  assign reset_pulse = (btn_hist_q[0] && !btn_hist_q[1]) || (s.reset_in && !btn_hist_q[2]);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_prev_q  <= 1'b0;
      en_cnt_q   <= 32'(EN_TOGGLE_CYCLES);
      btn_hist_q <= '0;
    end
    else
    begin
      en_prev_q  <= s.enable_in;
      btn_hist_q <= {s.reset_in, btn_hist_q[0], s.reset_btn};
      if (en_rise)
        en_cnt_q <= '0;
      else if (en_cnt_q < 32'(EN_TOGGLE_CYCLES))
        en_cnt_q <= en_cnt_q + 32'd1;
    end
  end

  // low bus debounce, reset hold timer, lamp test
  assign hold_done = (hold_cnt_q == 32'(CFG_HOLD_CYCLES));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lowbus_cnt_q <= '0;
      hold_cnt_q   <= '0;
      lamp_cnt_q   <= '0;
      lamp_q       <= 1'b1;
    end
    else
    begin
      if (bus_volts >= LOW_BUS_V)
        lowbus_cnt_q <= '0;
      else if (lowbus_cnt_q < 32'(LOWBUS_CYCLES))
        lowbus_cnt_q <= lowbus_cnt_q + 32'd1;
      if (!s.reset_btn)
        hold_cnt_q <= '0;
      else if (!hold_done)
        hold_cnt_q <= hold_cnt_q + 32'd1;
      if (lamp_cnt_q < 32'(LAMP_CYCLES))
        lamp_cnt_q <= lamp_cnt_q + 32'd1;
      else
        lamp_q <= 1'b0;
    end
  end

  // fault conditions
  assign pulse_mode = (ctrl_q.mode == MODE_PULSE) || (ctrl_q.mode == MODE_SUM_PLS);
  assign pls_lhs = 40'(pulse_hz) * 40'(SEC_PER_MIN);
  assign pls_rhs = 40'(PULSE_RPM_MAX) * 40'(pulse_ratio_q);
  assign spd_x2  = {1'b0, speed_rpm, 1'b0};
  assign max_x3  = 18'({motor_max_q, 1'b0}) + 18'(motor_max_q);
  always_comb
  begin
    cond          = '0;
    cond[F_PUT]   = selftest_fail;
    cond[F_MEM]   = mem_check_done && !mem_check_ok;
    cond[F_CFG]   = strap_done_q && cfg_strap_q && !lamp_q;
    cond[F_PWR]   = s.ps_overtemp || s.ps_overcur || s.ps_logic_loss
                    || (en_rise && en_cnt_q < 32'(EN_TOGGLE_CYCLES));
    cond[F_HBUS]  = bus_volts > HIGH_BUS_V;
    cond[F_LBUS]  = lowbus_cnt_q == 32'(LOWBUS_CYCLES);
    cond[F_ENCS]  = ctrl_q.enc_chk_en && enc_illegal;
    cond[F_ENCH]  = (s.enc[5] == s.enc[4]) || (s.enc[3] == s.enc[2])
                    || (s.enc[1] == s.enc[0]);
    cond[F_MOT]   = s.therm_open;
    cond[F_SHUNT] = s.shunt_over;
    cond[F_OSPD]  = (speed_rpm > speed_ceil_q) || (spd_x2 > max_x3)
                    || (pulse_mode && pls_lhs > pls_rhs);
    cond[F_FERR]  = pulse_mode && ctrl_q.fe_chk_en && (follow_err > fe_limit_q);
    cond[F_TRAV]  = s.lim_pos || s.lim_neg;
    if (lamp_q)
      cond = '0; // lamp test still running after reset
  end

  // latch, clear paths; a live condition always beats a clear
  always_comb
  begin
    clr = (reset_pulse ? RESET_MASK : '0) & ~cond;
    clr[F_CFG] = hold_done && !cond[F_CFG];
    flt_d = cond | (flt_q & ~clr);
    flt_d[F_TRAV] = cond[F_TRAV];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flt_q <= '0;
    else
      flt_q <= flt_d;
  end

  // highest-ranked active fault
  always_comb
  begin
    top_idx = '0;
    any_flt = |flt_q;
    for (int i = NFLT - 1; i >= 0; i--)
    begin
      if (flt_q[i])
        top_idx = 4'(i);
    end
  end

  assign ready = bridge_en && !s.stop_in;
  always_comb
  begin
    if (lamp_q)
      disp_d = DSP_ALL_ON;
    else if (any_flt)
      disp_d = sfs_disp_e'(5'(top_idx) + 5'h01);
    else if (ctrl_q.brake_assigned && s.brake_engaged)
      disp_d = DSP_BRAKE;
    else if (!bridge_en)
      disp_d = DSP_DISABLED;
    else if (s.rms_fold)
      disp_d = DSP_RMSFOLD;
    else if (s.stall_fold)
      disp_d = DSP_STALL;
    else
    begin
      case (ctrl_q.mode)
        MODE_PULSE:    disp_d = DSP_POSITION;
        MODE_VELOCITY: disp_d = DSP_VELOCITY;
        MODE_TORQUE:   disp_d = DSP_TORQUE;
        MODE_SUM_PLS:  disp_d = DSP_SUMMING;
        MODE_SUM_VEL:  disp_d = DSP_SUMMING;
        default:       disp_d = DSP_DISABLED;
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bridge_en          <= 1'b0;
      motion_en          <= 1'b0;
      disp_code          <= DSP_ALL_ON;
      disp_dp            <= 1'b1;
      torque_clamp_state <= 1'b0;
      torque_limit_pct   <= PCT_FULL;
      current_limit_pct  <= PCT_FULL;
    end
    else
    begin
      bridge_en          <= s.enable_in && !lamp_q && !(|(flt_q & BRIDGE_MASK));
      motion_en          <= motion_cmd && ready;
      disp_code          <= disp_d;
      disp_dp            <= lamp_q || ready;
      torque_clamp_state <= s.rms_fold;
      torque_limit_pct   <= s.rms_fold ? PCT_FOLD : PCT_FULL;
      current_limit_pct  <= s.stall_fold ? PCT_FOLD : PCT_FULL;
    end
  end

  // apb slave: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else if (psel && !penable)
    begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= '0;
      case (paddr)
        REG_CTRL:        prdata <= 32'(ctrl_q);
        REG_SPEED_CEIL:  prdata <= 32'(speed_ceil_q);
        REG_MOTOR_MAX:   prdata <= 32'(motor_max_q);
        REG_FE_LIMIT:    prdata <= 32'(fe_limit_q);
        REG_PULSE_RATIO: prdata <= 32'(pulse_ratio_q);
        REG_FAULTS:      prdata <= 32'(flt_q);
        REG_POSITION:    prdata <= pos_q;
        REG_DISPLAY:     prdata <= 32'({disp_dp, disp_code});
        default:         pslverr <= 1'b1;
      endcase
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q        <= sfs_ctrl_s'(CTRL_RST[5:0]);
      speed_ceil_q  <= SPEED_CEIL_RST;
      motor_max_q   <= MOTOR_MAX_RST;
      fe_limit_q    <= FE_LIMIT_RST;
      pulse_ratio_q <= PULSE_RATIO_RST;
    end
    else if (psel && penable && pready && pwrite)
    begin
      case (paddr)
        REG_CTRL:        ctrl_q        <= sfs_ctrl_s'(pwdata[5:0]);
        REG_SPEED_CEIL:  speed_ceil_q  <= pwdata[15:0];
        REG_MOTOR_MAX:   motor_max_q   <= pwdata[15:0];
        REG_FE_LIMIT:    fe_limit_q    <= pwdata[15:0];
        REG_PULSE_RATIO: pulse_ratio_q <= pwdata[15:0];
        default:         ;
      endcase
    end
  end

  // checks
  property p_fault_shown;
    @(posedge pclk) disable iff (!presetn)
    (!lamp_q && |flt_q) |=> (disp_code == 5'($past(top_idx)) + 5'h01);
  endproperty
  a_fault_shown: assert property (p_fault_shown) else $error("fault code not shown");
  property p_dp;
    @(posedge pclk) disable iff (!presetn)
    (!$past(lamp_q) && disp_dp) |-> $past(bridge_en) && !$past(s.stop_in);
  endproperty
  a_dp: assert property (p_dp) else $error("ready point lit while not ready");
  property p_motion;
    @(posedge pclk) disable iff (!presetn)
    motion_en |-> $past(ready) && $past(motion_cmd);
  endproperty
  a_motion: assert property (p_motion) else $error("motion while not ready");
  property p_brake;
    @(posedge pclk) disable iff (!presetn)
    (disp_code == DSP_BRAKE) |-> $past(ctrl_q.brake_assigned);
  endproperty
  a_brake: assert property (p_brake) else $error("brake shown while unassigned");
  property p_clamp;
    @(posedge pclk) disable iff (!presetn)
    s.rms_fold |=> torque_limit_pct == PCT_FOLD && torque_clamp_state;
  endproperty
  a_clamp: assert property (p_clamp) else $error("torque not clamped");
  property p_rank;
    @(posedge pclk) disable iff (!presetn)
    flt_q[F_PUT] |-> top_idx == 4'(F_PUT);
  endproperty
  a_rank: assert property (p_rank) else $error("wrong fault ranked first");
  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
    flt_q[F_ENCH] |=> flt_q[F_ENCH];
  endproperty
  a_sticky: assert property (p_sticky) else $error("power-cycle fault cleared");
  property p_bridge;
    @(posedge pclk) disable iff (!presetn)
    |(flt_q & BRIDGE_MASK) |=> !bridge_en;
  endproperty
  a_bridge: assert property (p_bridge) else $error("bridge on during fault");
  property p_travel;
    @(posedge pclk) disable iff (!presetn)
    $fell(cond[F_TRAV]) |=> !flt_q[F_TRAV];
  endproperty
  a_travel: assert property (p_travel) else $error("travel fault not auto cleared");
  property p_hbus;
    @(posedge pclk) disable iff (!presetn)
    (bus_volts > HIGH_BUS_V && !lamp_q) ##1 !reset_pulse |-> flt_q[F_HBUS] [*2];
  endproperty
  a_hbus: assert property (p_hbus) else $error("high bus not latched");
  property p_reset_keep;
    @(posedge pclk) disable iff (!presetn)
    (flt_q[F_MOT] && cond[F_MOT]) |=> flt_q[F_MOT];
  endproperty
  a_reset_keep: assert property (p_reset_keep) else $error("live fault cleared");
  c_fault: cover property (@(posedge pclk) disable iff (!presetn) $rose(flt_q[F_HBUS]));
  c_clear: cover property (@(posedge pclk) disable iff (!presetn) $fell(flt_q[F_MOT]));
  c_ready: cover property (@(posedge pclk) disable iff (!presetn) $rose(disp_dp) && !lamp_q);
  c_travel: cover property (@(posedge pclk) disable iff (!presetn) $fell(flt_q[F_TRAV]));
endmodule
`default_nettype wire

// ### design/sfs_unused_guard.sv
`default_nettype none
`default_nettype wire

// ### testbench/sfs_supervisor_tb.sv
`default_nettype none
module sfs_supervisor_tb
  import sfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAMP = 10;
  localparam int CFGH = 30;
  logic        pclk           = 1'b0;
  logic        presetn        = 1'b0;
  logic        psel           = 1'b0;
  logic        penable        = 1'b0;
  logic        pwrite         = 1'b0;
  logic [7:0]  paddr          = 8'h00;
  logic [31:0] pwdata         = 32'h0;
  sfs_pins_s   pins           = 24'h200066;
  logic [9:0]  bus_volts      = 10'h12C;
  logic [15:0] speed_rpm      = 16'h0;
  logic [15:0] follow_err     = 16'h0;
  logic [19:0] pulse_hz       = 20'h0;
  logic        selftest_fail  = 1'b0;
  logic        mem_check_done = 1'b1;
  logic        mem_check_ok   = 1'b1;
  logic        motion_cmd     = 1'b0;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        bridge_en;
  logic        motion_en;
  logic [4:0]  disp_code;
  logic        disp_dp;
  logic        torque_clamp_state;
  logic [7:0]  torque_limit_pct;
  logic [7:0]  current_limit_pct;
  logic [31:0] rd;
  logic        er;
  logic [31:0] p0;
  int          fail_count     = 0;
  int          checks_done    = 0;
  // overspeed and following error cases: ctrl, ceiling, max, speed, pulse hz, ratio, error, bit
  int tc[11]  = '{0, 0, 0, 0, 0, 3, 16, 16, 17, 0, 1};
  int tce[11] = '{1000, 1000, 65535, 65535, 65535, 65535, 65535, 65535, 65535, 65535, 65535};
  int tmx[11] = '{6000, 6000, 1000, 1000, 6000, 6000, 6000, 6000, 6000, 6000, 6000};
  int tsp[11] = '{1000, 1001, 1500, 1501, 0, 0, 0, 0, 0, 0, 0};
  int thz[11] = '{0, 0, 0, 0, 2166, 2167, 0, 0, 0, 0, 2167};
  int trt[11] = '{2048, 2048, 2048, 2048, 10, 10, 2048, 2048, 2048, 2048, 10};
  int tfe[11] = '{0, 0, 0, 0, 0, 0, 200, 201, 201, 201, 0};
  int tex[11] = '{-1, 10, -1, 10, -1, 10, -1, 11, -1, -1, -1};
  int pidx[7] = '{19, 17, 18, 16, 15, 14, 13};
  int pbit[7] = '{8, 12, 12, 3, 3, 3, 9};
  logic [31:0] rv[5] = '{32'h3, 32'h1770, 32'h1770, 32'hC8, 32'h800};
  logic [4:0]  dm[5] = '{DSP_POSITION, DSP_VELOCITY, DSP_TORQUE, DSP_SUMMING, DSP_SUMMING};
  logic [5:0]  es[4] = '{6'b101010, 6'b011010, 6'b010110, 6'b100110};

  sfs_supervisor #(
    .LOWBUS_CYCLES   (20),
    .CFG_HOLD_CYCLES (CFGH),
    .LAMP_CYCLES     (LAMP),
    .EN_TOGGLE_CYCLES(16)
  ) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .pins(pins), .bus_volts(bus_volts), .speed_rpm(speed_rpm), .follow_err(follow_err),
    .pulse_hz(pulse_hz), .selftest_fail(selftest_fail), .mem_check_done(mem_check_done),
    .mem_check_ok(mem_check_ok), .motion_cmd(motion_cmd), .bridge_en(bridge_en),
    .motion_en(motion_en), .disp_code(disp_code), .disp_dp(disp_dp),
    .torque_clamp_state(torque_clamp_state), .torque_limit_pct(torque_limit_pct),
    .current_limit_pct(current_limit_pct)
  );

  always #4 pclk = ~pclk;

  task summarize();
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task setp(input int i, input logic v);
    @(posedge pclk);
    pins[i] <= v;
  endtask

  task press(input int i, input int n);
    setp(i, 1'b1);
    wt(n);
    setp(i, 1'b0);
    wt(8);
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", {31'h0, pready}, 32'h1);
  endtask

  task flt(input logic [12:0] e);
    apb(1'b0, REG_FAULTS, 32'h0);
    chk("faults", rd, {19'h0, e});
  endtask

  task power_cycle();
    @(posedge pclk);
    presetn <= 1'b0;
    wt(16);
    chk("lamp_reset", {27'h0, disp_code}, {27'h0, DSP_ALL_ON});
    presetn <= 1'b1;
    wt(3);
    chk("lamp_on", {26'h0, bridge_en, disp_code}, {27'h0, DSP_ALL_ON});
    wt(LAMP + 8);
    chk("lamp_off", 32'(disp_code == DSP_ALL_ON), 32'h0);
  endtask

  initial
  begin
    #320000;
    fail_count++;
    $display("[FAIL] watchdog expected done seen hang");
    summarize();
  end

  initial
  begin
    power_cycle();
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reg_reset", rd, rv[i]);
    end
    apb(1'b1, REG_FAULTS, 32'h1FFF);
    chk("ro_err", {31'h0, er}, 32'h0);
    flt(13'h0);
    apb(1'b1, 8'h20, 32'hFFFF);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_rd", {er, rd[30:0]}, 32'h80000000);
    // ready point and motion gating
    motion_cmd <= 1'b1;
    wt(6);
    chk("ready", {30'h0, disp_dp, motion_en}, 32'h3);
    setp(20, 1'b1);
    wt(8);
    chk("stop", {30'h0, disp_dp, motion_en}, 32'h0);
    setp(20, 1'b0);
    setp(21, 1'b0);
    wt(8);
    chk("disabled", {26'h0, disp_dp, disp_code}, {27'h0, DSP_DISABLED});
    chk("dis_motion", {31'h0, motion_en}, 32'h0);
    wt(20);
    setp(21, 1'b1);
    wt(8);
    flt(13'h0);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, REG_CTRL, 32'(i));
      wt(6);
      chk("mode_disp", {27'h0, disp_code}, {27'h0, dm[i]});
    end
    setp(10, 1'b1);
    wt(8);
    chk("brake_unassigned", {27'h0, disp_code}, {27'h0, DSP_SUMMING});
    apb(1'b1, REG_CTRL, 32'h0B);
    wt(6);
    chk("brake_assigned", {27'h0, disp_code}, {27'h0, DSP_BRAKE});
    apb(1'b1, REG_CTRL, 32'h03);
    setp(10, 1'b0);
    setp(12, 1'b1);
    wt(8);
    chk("rms", {10'h0, torque_clamp_state, torque_limit_pct, current_limit_pct, disp_code},
        {10'h0, 1'b1, PCT_FOLD, PCT_FULL, DSP_RMSFOLD});
    setp(12, 1'b0);
    setp(11, 1'b1);
    wt(8);
    chk("stall", {10'h0, torque_clamp_state, torque_limit_pct, current_limit_pct, disp_code},
        {10'h0, 1'b0, PCT_FULL, PCT_FOLD, DSP_STALL});
    setp(11, 1'b0);
    // pin faults: latch, bridge, code, reset while present, clearing path
    for (int i = 0; i < 7; i++)
    begin
      setp(pidx[i], 1'b1);
      wt(8);
      flt(13'h1 << pbit[i]);
      chk("bridge", {31'h0, bridge_en}, 32'(pbit[i] == 12));
      chk("code", {27'h0, disp_code}, 32'(pbit[i] + 1));
      press(22 + i % 2, 4);
      flt(13'h1 << pbit[i]);
      setp(pidx[i], 1'b0);
      wt(8);
      if (pbit[i] != 12)
        press(23 - i % 2, 4);
      flt(13'h0);
    end
    setp(19, 1'b1);
    bus_volts <= 10'h1B8;
    wt(8);
    chk("prio_440", {27'h0, disp_code}, 32'h9);
    bus_volts <= 10'h1B9;
    wt(8);
    chk("prio_441", {27'h0, disp_code}, 32'h5);
    flt(13'h0110);
    chk("hbus_bridge", {31'h0, bridge_en}, 32'h0);
    bus_volts <= 10'h12C;
    setp(19, 1'b0);
    press(23, 4);
    flt(13'h0);
    bus_volts <= 10'h05F;
    wt(10);
    flt(13'h0);
    wt(20);
    flt(13'h0020);
    apb(1'b0, REG_POSITION, 32'h0);
    p0 = rd;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge pclk);
      pins.enc <= es[k];
      wt(4);
    end
    apb(1'b0, REG_POSITION, 32'h0);
    chk("position", 32'((rd - p0 == 32'h4) || (p0 - rd == 32'h4)), 32'h1);
    bus_volts <= 10'h060;
    wt(30);
    press(23, 4);
    flt(13'h0);
    setp(21, 1'b0);
    wt(20);
    setp(21, 1'b1);
    wt(4);
    setp(21, 1'b0);
    wt(4);
    setp(21, 1'b1);
    wt(8);
    flt(13'h0008);
    press(22, 4);
    for (int i = 0; i < 11; i++)
    begin
      apb(1'b1, REG_CTRL, 32'(tc[i]));
      apb(1'b1, REG_SPEED_CEIL, 32'(tce[i]));
      apb(1'b1, REG_MOTOR_MAX, 32'(tmx[i]));
      apb(1'b1, REG_PULSE_RATIO, 32'(trt[i]));
      speed_rpm <= 16'(tsp[i]);
      pulse_hz <= 20'(thz[i]);
      follow_err <= 16'(tfe[i]);
      wt(8);
      flt(tex[i] < 0 ? 13'h0 : 13'h1 << tex[i]);
      speed_rpm <= 16'h0;
      pulse_hz <= 20'h0;
      follow_err <= 16'h0;
      press(22, 4);
    end
    // encoder faults survive a reset request
    apb(1'b1, REG_CTRL, 32'h03);
    @(posedge pclk);
    pins.enc <= 6'b011010;
    wt(8);
    flt(13'h0);
    apb(1'b1, REG_CTRL, 32'h23);
    @(posedge pclk);
    pins.enc <= 6'b100110;
    wt(8);
    flt(13'h0040);
    press(23, 4);
    flt(13'h0040);
    @(posedge pclk);
    pins.enc <= 6'b110110;
    wt(8);
    flt(13'h00C0);
    chk("enc_code", {27'h0, disp_code}, 32'h7);
    pins.enc <= 6'b100110;
    selftest_fail <= 1'b1;
    mem_check_ok <= 1'b0;
    setp(9, 1'b1);
    power_cycle();
    flt(13'h0007);
    chk("top_code", {27'h0, disp_code}, 32'h1);
    mem_check_ok <= 1'b1;
    press(23, 4);
    flt(13'h0005);
    press(23, CFGH + 10);
    flt(13'h0001);
    selftest_fail <= 1'b0;
    setp(9, 1'b0);
    power_cycle();
    flt(13'h0);
    chk("bridge_clean", {31'h0, bridge_en}, 32'h1);
    summarize();
  end
endmodule
`default_nettype wire
